// *** lds_cfg.svh ***
// Constants for the display link serializer.
// Assumes a 125 MHz ref_clk; times are converted to cycles here.
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

`define LDS_REF_CLK_KHZ      125000
`define LDS_IN_BITS          21
`define LDS_LANES            3
`define LDS_SLOTS            7
`define LDS_SLOT_W           3
`define LDS_SLOT_LAST        3'h6
`define LDS_CLK_HIGH_SLOTS   3'h4
`define LDS_LANE0_LSB        0
`define LDS_LANE1_LSB        7
`define LDS_LANE2_LSB        14
`define LDS_FIFO_DEPTH       4
`define LDS_PLL_LOCK_MS      10
`define LDS_PLL_LOCK_CYC     (`LDS_PLL_LOCK_MS * `LDS_REF_CLK_KHZ)
`define LDS_PD_DELAY_NS      100
`define LDS_PD_DELAY_CYC     ((`LDS_PD_DELAY_NS * `LDS_REF_CLK_KHZ) / 1000000)
`define LDS_LOSS_CYC         64
`define LDS_CNT_W            21

`endif

// *** lds_pkg.sv ***
// Types for the display link serializer.
// Field positions are fixed here; they match the lane LSBs in lds_cfg.svh.
package lds_pkg;

  // One pixel word, split into its three lane groups
  typedef struct packed {
    logic [6:0] lane2;
    logic [6:0] lane1;
    logic [6:0] lane0;
  } lds_word_t;

  typedef enum logic [1:0] {
    LDS_DOWN,
    LDS_ACQ,
    LDS_LOCKED
  } lds_state_t;

endpackage : lds_pkg

// *** lds_serializer.sv ***
// Display link serializer: pin capture, pixel FIFO, 7:1 lane serializer.
// Assumes all pins are asynchronous to ref_clk; lane pins are driven
// single-ended with an output enable, the pad makes the pair.
`timescale 1ns/1ps
`default_nettype none
`include "lds_cfg.svh"

////////////////////////////////////////////////////////////////////////////
module lds_fifo #(
  parameter int WIDTH = `LDS_IN_BITS,
  parameter int DEPTH = `LDS_FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_r != '0) && !flush;
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
    nxt_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt_ptr

  always_comb begin
    wr_nxt  = push ? nxt_ptr(wr_r) : wr_r;
    rd_nxt  = pop ? nxt_ptr(rd_r) : rd_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  a_fifo_no_over: assert property (
    @(posedge ref_clk) disable iff (!rst_b) cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : lds_fifo

////////////////////////////////////////////////////////////////////////////
// What this block does
// - Take 21 inputs per pixel: 18 colour bits, line sync, frame sync, enable.
// - Capture every input bit only on the pixel shift clock falling edge.
// - Drive serialized pixel data on three data lanes every clock period.
// - Lane 0 carries bits 0-6, lane 1 bits 7-13, lane 2 bits 14-20.
// - Forward a link clock on a fourth lane, one period per seven slots.
// - Power-down low puts every serial output in high impedance.
// - Power-down resets internal state and stops the lock logic.
// - Any order of power-down release and clock or data arrival works.
// - Clock stop and restart relocks and resumes without power-down.
// - Output tracks a spread-spectrum input up to 100KHz modulation.
// - Lock and valid output within 10 ms of a stable input clock.
// - Outputs disabled within 100 ns of power-down assertion.
module lds_serializer #(
  parameter int LOCK_CYC = `LDS_PLL_LOCK_CYC,
  parameter int LOSS_CYC = `LDS_LOSS_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      clk_en,
  input  wire logic                      pixel_shift_clock_in,
  input  wire logic [`LDS_IN_BITS-1:0]   pixel_input_bits,
  input  wire logic                      power_down_n,
  output logic      [`LDS_LANES-1:0]     serial_data_lane,
  output logic      [`LDS_LANES-1:0]     serial_data_lane_oe,
  output logic                           forwarded_link_clock,
  output logic                           forwarded_link_clock_oe,
  output logic                           pll_locked,
  output logic                           capture_ready
);
  localparam int PD_CYC = `LDS_PD_DELAY_CYC;

  // Two-flop synchronisers for every pin input
  logic [`LDS_IN_BITS-1:0] din_s1_r, din_s2_r;
  logic [2:0]              clk_s_r;
  logic [1:0]              pd_s_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
      clk_s_r  <= '0;
      pd_s_r   <= '0;
    end else if (clk_en) begin
      din_s1_r <= pixel_input_bits;
      din_s2_r <= din_s1_r;
      clk_s_r  <= {clk_s_r[1:0], pixel_shift_clock_in};
      pd_s_r   <= {pd_s_r[0], power_down_n};
    end
  end

  logic fall_det, standby;
  assign fall_det = clk_s_r[2] && !clk_s_r[1];
  assign standby  = !pd_s_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Lock tracking and serializer state
  lds_pkg::lds_state_t       st_r, st_nxt;
  logic [`LDS_CNT_W-1:0]     lock_cnt_r, lock_cnt_nxt;
  logic [6:0]                gap_r, gap_nxt;
  logic [`LDS_SLOT_W-1:0]    slot_r, slot_nxt;
  lds_pkg::lds_word_t        sh_r, sh_nxt;
  logic [`LDS_LANES-1:0]     lane_nxt;
  logic                      fclk_nxt, oe_r, oe_nxt;
  logic                      locked;
  logic                      fifo_out_valid, fifo_pop;
  lds_pkg::lds_word_t        fifo_word, cap_word;

  assign locked = (st_r == lds_pkg::LDS_LOCKED);
  assign cap_word = lds_pkg::lds_word_t'(din_s2_r);
  assign fifo_pop = locked && (slot_r == `LDS_SLOT_LAST);

  lds_fifo #(
    .WIDTH (`LDS_IN_BITS),
    .DEPTH (`LDS_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .flush     (!locked),
    .in_valid  (fall_det && locked),
    .in_ready  (capture_ready),
    .in_data   (cap_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  always_comb begin
    st_nxt       = st_r;
    lock_cnt_nxt = lock_cnt_r;
    // Saturates so a stopped clock parks the lock counter
    gap_nxt      = fall_det ? '0 :
                   (gap_r == 7'(LOSS_CYC)) ? gap_r : gap_r + 1'b1;
    slot_nxt     = `LDS_SLOT_LAST;
    sh_nxt       = '0;
    oe_nxt       = 1'b1;
    unique case (st_r)
      lds_pkg::LDS_DOWN: begin
        st_nxt       = lds_pkg::LDS_ACQ;
        lock_cnt_nxt = '0;
      end
      lds_pkg::LDS_ACQ: begin
        if (gap_r == 7'(LOSS_CYC)) begin
          lock_cnt_nxt = '0;
        end else if (lock_cnt_r == `LDS_CNT_W'(LOCK_CYC - 1)) begin
          st_nxt = lds_pkg::LDS_LOCKED;
        end else begin
          lock_cnt_nxt = lock_cnt_r + 1'b1;
        end
      end
      lds_pkg::LDS_LOCKED: begin
        if (gap_r == 7'(LOSS_CYC)) begin
          st_nxt       = lds_pkg::LDS_ACQ;
          lock_cnt_nxt = '0;
        end else if (slot_r == `LDS_SLOT_LAST) begin
          slot_nxt = '0;
          // Empty FIFO sends a zero word; clock keeps running
          sh_nxt   = fifo_out_valid ? fifo_word : '0;
        end else begin
          slot_nxt = slot_r + 1'b1;
          sh_nxt.lane0 = {sh_r.lane0[5:0], 1'b0};
          sh_nxt.lane1 = {sh_r.lane1[5:0], 1'b0};
          sh_nxt.lane2 = {sh_r.lane2[5:0], 1'b0};
        end
      end
      default: begin
        st_nxt = lds_pkg::LDS_DOWN;
      end
    endcase
    if (standby) begin
      st_nxt       = lds_pkg::LDS_DOWN;
      lock_cnt_nxt = '0;
      // No edge seen yet after standby
      gap_nxt      = 7'(LOSS_CYC);
      oe_nxt       = 1'b0;
    end
    // Slot k carries bit 6-k of each lane group
    lane_nxt = {sh_nxt.lane2[6], sh_nxt.lane1[6], sh_nxt.lane0[6]};
    fclk_nxt = (st_nxt == lds_pkg::LDS_LOCKED) &&
               (slot_nxt < `LDS_CLK_HIGH_SLOTS);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r                 <= lds_pkg::LDS_DOWN;
      lock_cnt_r           <= '0;
      gap_r                <= 7'(LOSS_CYC);
      slot_r               <= `LDS_SLOT_LAST;
      sh_r                 <= '0;
      oe_r                 <= 1'b0;
      serial_data_lane     <= '0;
      forwarded_link_clock <= 1'b0;
    end else if (clk_en) begin
      st_r                 <= st_nxt;
      lock_cnt_r           <= lock_cnt_nxt;
      gap_r                <= gap_nxt;
      slot_r               <= slot_nxt;
      sh_r                 <= sh_nxt;
      oe_r                 <= oe_nxt;
      serial_data_lane     <= lane_nxt;
      forwarded_link_clock <= fclk_nxt;
    end
  end

  assign serial_data_lane_oe     = {`LDS_LANES{oe_r}};
  assign forwarded_link_clock_oe = oe_r;
  assign pll_locked              = locked;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !clk_en);

  sequence s_pd_low;
    !pd_s_r[1];
  endsequence
  sequence s_outputs_off;
    !oe_r && !serial_data_lane_oe[0] && !forwarded_link_clock_oe;
  endsequence

  a_pd_tristate: assert property (s_pd_low |=> s_outputs_off)
    else $error("outputs not off in standby");
  a_pd_delay_bound: assert property ($fell(pd_s_r[1]) |-> ##1 !oe_r)
    else $error("outputs off too late");
  a_pd_resets_lock: assert property (s_pd_low |=> st_r == lds_pkg::LDS_DOWN)
    else $error("standby did not reset state");
  a_down_to_acq: assert property (st_r == lds_pkg::LDS_DOWN && pd_s_r[1]
      |=> st_r == lds_pkg::LDS_ACQ)
    else $error("no acquire after release");
  a_clk_shape: assert property (
      disable iff (!rst_b || !clk_en || standby || gap_r == 7'(LOSS_CYC))
      locked && slot_r == 3'h0 && $past(locked)
      |-> forwarded_link_clock ##1 forwarded_link_clock[*3]
      ##1 !forwarded_link_clock)
    else $error("forwarded clock shape wrong");
  a_slot_loop: assert property (locked && slot_r == `LDS_SLOT_LAST
      && pd_s_r[1] && gap_r != 7'(LOSS_CYC) |=> slot_r == 3'h0)
    else $error("slot counter did not wrap");
  a_lane_map: assert property (fifo_pop && fifo_out_valid && pd_s_r[1]
      && gap_r != 7'(LOSS_CYC) |=> serial_data_lane ==
      {$past(fifo_word.lane2[6]), $past(fifo_word.lane1[6]),
       $past(fifo_word.lane0[6])})
    else $error("lane slot 0 mismatch");
  a_loss_relock: assert property (locked && gap_r == 7'(LOSS_CYC)
      && pd_s_r[1] |=> st_r == lds_pkg::LDS_ACQ)
    else $error("clock loss not detected");
  a_capture_edge: assert property (u_fifo.push |-> fall_det)
    else $error("capture without falling edge");
  a_pd_pin_delay: assert property (!power_down_n
      |-> ##[1:PD_CYC] !oe_r)
    else $error("outputs off too late after pin");
endmodule : lds_serializer
`default_nettype wire

// *** lds_src.sv ***
// Pixel source model: free-running pixel clock, words from a queue.
// Assumes ref_clk; half gives the pixel clock half period in ref cycles.
`timescale 1ns/1ps
`default_nettype none

module lds_src (
  input  wire logic         ref_clk,
  input  wire logic         run,
  input  wire logic [3:0]   half,
  output var  logic         pix_clk,
  output var  lds_pkg::lds_word_t pix_data
);
  lds_pkg::lds_word_t q[$];
  logic [4:0] ph_r;
  initial begin
    pix_clk = 1'b1;
    pix_data = '0;
    ph_r = 5'h00;
  end
  always @(posedge ref_clk) begin
    if (run) begin
      ph_r <= (ph_r == {half, 1'b0} - 5'h01) ? 5'h00 : ph_r + 5'h01;
      if (ph_r == 5'h00) begin
        // New word at the rising edge, held across the strobe
        pix_clk <= 1'b1;
        pix_data <= (q.size() > 0) ? q.pop_front() : '0;
      end else if (ph_r == {1'b0, half}) begin
        pix_clk <= 1'b0;
      end
    end else begin
      // Stopped: clock idles high, data no longer held
      ph_r <= 5'h00;
      pix_clk <= 1'b1;
      pix_data <= ~pix_data;
    end
  end
endmodule : lds_src

`default_nettype wire

// *** lds_serializer_tb.sv ***
// Testbench for lds_serializer with a pixel source model.
// Assumes lds_src.sv; deserializes the lanes against the forwarded clock.
`timescale 1ns/1ps
`default_nettype none

module lds_serializer_tb;
  logic ref_clk, rst_b, clk_en, power_down_n, run, pll_locked, capture_ready;
  logic [3:0] half;
  logic [2:0] lane, lane_oe;
  logic fclk, fclk_oe, prev_clk, pix_clk, en_d;
  lds_pkg::lds_word_t pix_data, acc, exp_q[$];
  int fail_count, n_tests, slot;
  logic [31:0] seed;
  bit saw_full;

  lds_src src (.ref_clk(ref_clk), .run(run), .half(half),
               .pix_clk(pix_clk), .pix_data(pix_data));
  lds_serializer #(.LOCK_CYC(20), .LOSS_CYC(64)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .pixel_shift_clock_in(pix_clk), .pixel_input_bits(pix_data),
    .power_down_n(power_down_n), .serial_data_lane(lane),
    .serial_data_lane_oe(lane_oe), .forwarded_link_clock(fclk),
    .forwarded_link_clock_oe(fclk_oe), .pll_locked(pll_locked),
    .capture_ready(capture_ready));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // Lane receiver: slot 0 follows the forwarded clock rise
  always @(posedge ref_clk) begin
    prev_clk <= fclk;
    en_d     <= clk_en;
    // Outputs held by a low clock enable are skipped
    if (en_d !== 1'b0) begin
      if (!pll_locked || !fclk_oe) slot = 7;
      else if (fclk && !prev_clk) slot = 0;
      else if (slot != 7) slot = slot + 1;
      if (slot < 7) begin
        check(21'(fclk), 21'(slot < 4));
        for (int l = 0; l < 3; l++) acc[l*7+6-slot] = lane[l];
        if (slot == 6 && acc != '0 && exp_q.size() > 0)
          check(acc, exp_q.pop_front());
      end
      if (!capture_ready && pll_locked) saw_full = 1'b1;
    end
  end

  task automatic wait_lock();
    for (int i = 0; i < 300 && pll_locked !== 1'b1; i++) @(posedge ref_clk);
    check(21'(pll_locked), 21'h000001);
  endtask : wait_lock

  task automatic burst(input int n, input bit cmp);
    lds_pkg::lds_word_t w;
    logic [31:0]        r;
    for (int i = 0; i < n; i++) begin
      case (i)
        0: w = 21'h1FFFFF;
        1: w = 21'h000001;
        2: w = 21'h100000;
        3: w = 21'h003F80;
        default: begin
          r = xorshift();
          w = r[20:0];
        end
      endcase
      if (w == '0) w = 21'h000001;
      src.q.push_back(w);
      if (cmp) exp_q.push_back(w);
    end
    for (int i = 0; i < n * 40 + 100 && (exp_q.size() > 0 ||
         src.q.size() > 0); i++) @(posedge ref_clk);
    repeat (60) @(posedge ref_clk);
    check(21'(exp_q.size()), 21'h000000);
  endtask : burst

  initial begin
    seed = 32'h00000012;
    rst_b = 1'b0;
    clk_en = 1'b1;
    power_down_n = 1'b1;
    run = 1'b0;
    half = 4'h5;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run <= 1'b1;
    wait_lock();
    burst(24, 1'b1);
    half <= 4'h6;
    burst(8, 1'b1);
    half <= 4'h2;
    burst(16, 1'b0);
    check(21'(saw_full), 21'h000001);
    check(21'(capture_ready), 21'h000001);
    half <= 4'h5;
    run <= 1'b0;
    repeat (80) @(posedge ref_clk);
    #1 check(21'(pll_locked), 21'h000000);
    @(posedge ref_clk);
    run <= 1'b1;
    wait_lock();
    burst(8, 1'b1);
    power_down_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check(21'({lane_oe, fclk_oe}), 21'h00000F);
    @(posedge ref_clk);
    #1 check(21'({lane_oe, fclk_oe}), 21'h000000);
    repeat (40) @(posedge ref_clk);
    check(21'({pll_locked, lane}), 21'h000000);
    run <= 1'b0;
    power_down_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    run <= 1'b1;
    wait_lock();
    burst(12, 1'b1);
    // Frozen block must not see the stopped clock as a loss
    clk_en <= 1'b0;
    run    <= 1'b0;
    repeat (100) @(posedge ref_clk);
    check(21'({pll_locked, fclk_oe}), 21'h000003);
    clk_en <= 1'b1;
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
endmodule : lds_serializer_tb

`default_nettype wire
